//--- src/rfe_pkg.sv
// Operation
// - overshoot pattern follows every modulation rising edge
// - pattern length is field plus one, MSB first
// - protection only while enable bit is set
// - miller pulse lasts width plus one cycles
// - first prescaler load uses bit-phase value
// - prescaler counter decrements every carrier cycle
// - prescaler wrap decrements wait counter and reloads
// - later prescaler reloads use programmed reload value
// - zero wait value skips guard time
// - mode detector overwrites wait and prescaler fields
// - guard cycles precede every frame unless the wait value is zero
// - parity bit appended after every byte when enabled
// - parity type: zero even, one odd
// - final byte parity inverted when flip bit set
// - data enabled with zero byte count flags error
// - data enable sends bytes, else symbols only
// - stop field picks none or symbols one to three
// - start field picks none or symbols zero to two
// - last-bits field trims trailing bits of last byte
// - first-bits field trims leading bits of first byte
package rfe_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_OVERSHOOT = 8'h15;
  localparam logic [7:0] OFS_PULSE_PHASE = 8'h16;
  localparam logic [7:0] OFS_GUARD = 8'h17;
  localparam logic [7:0] OFS_FRAMING = 8'h18;
  localparam logic [7:0] OFS_COMMAND = 8'h1C;
  localparam logic [7:0] OFS_BYTE_COUNT = 8'h1D;
  localparam logic [7:0] OFS_STATUS = 8'h1E;
  // field positions
  localparam int POS_OS_PATTERN = 16;
  localparam int POS_OS_LEN = 1;
  localparam int POS_OS_ON = 0;
  localparam int POS_PULSE_WIDTH = 8;
  localparam int POS_PHASE = 0;
  localparam int POS_WAIT_VALUE = 8;
  localparam int POS_PRESCALER = 0;
  localparam int POS_FINAL_FLIP = 13;
  localparam int POS_PAR_TYPE = 12;
  localparam int POS_PAR_EN = 11;
  localparam int POS_DATA_EN = 10;
  localparam int POS_STOP_SYM = 8;
  localparam int POS_START_SYM = 6;
  localparam int POS_LAST_BITS = 3;
  localparam int POS_FIRST_BITS = 0;
  localparam int POS_CMD_START = 0;
  localparam int POS_ST_BUSY = 0;
  localparam int POS_ST_NO_DATA = 1;
  // reset values
  localparam logic [31:0] RST_OVERSHOOT = 32'h0000_0000;
  localparam logic [31:0] RST_PULSE_PHASE = 32'h0000_0000;
  localparam logic [31:0] RST_GUARD = 32'h0000_0000;
  localparam logic [31:0] RST_FRAMING = 32'h0000_0000;
  localparam logic [8:0] RST_BYTE_COUNT = 9'h000;
  // one bit slot on the carrier clock, long enough for the widest pulse
  localparam logic [8:0] SLOT_LAST = 9'h1FF;
  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_GUARD = 7'b000_0010,
    ST_START = 7'b000_0100,
    ST_LOAD = 7'b000_1000,
    ST_DBIT = 7'b001_0000,
    ST_PAR = 7'b010_0000,
    ST_STOP = 7'b100_0000
  } rfe_state_t;
endpackage

//--- src/rfe_tx_encoder.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
module rfe_tx_encoder (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic [rfe_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // mode detector
  input wire logic md_valid,
  input wire logic [19:0] md_wait_value,
  input wire logic [7:0] md_prescaler,
  // byte source
  input wire logic [7:0] byte_data,
  input wire logic byte_valid,
  output logic byte_ready,
  // modulation side
  output logic tx_mod,
  output logic tx_shape,
  output logic sym_strobe,
  output logic [1:0] sym_code,
  output logic frame_done
);
  import rfe_pkg::*;

  logic [31:0] os_reg, pp_reg, guard_reg, framing_reg;
  logic [8:0] count_reg;
  logic no_data_reg;
  rfe_state_t state_reg;
  logic [8:0] slot_reg;
  logic [7:0] pre_reg;
  logic [19:0] wait_reg;
  logic [7:0] byte_reg;
  logic [2:0] idx_reg;
  logic [3:0] left_reg;
  logic [8:0] bytes_reg;
  logic par_acc_reg;
  logic pulse_go_reg;
  logic [7:0] pulse_cnt_reg;
  logic mod_d_reg;
  logic os_active_reg;
  logic [3:0] os_idx_reg;
  logic [3:0] os_left_reg;

  wire os_on = os_reg[POS_OS_ON];
  wire [3:0] os_len = os_reg[POS_OS_LEN +: 4];
  wire [15:0] os_pat = os_reg[POS_OS_PATTERN +: 16];
  wire [7:0] pulse_width = pp_reg[POS_PULSE_WIDTH +: 8];
  wire [7:0] phase = pp_reg[POS_PHASE +: 8];
  wire [19:0] wait_value = guard_reg[POS_WAIT_VALUE +: 20];
  wire [7:0] prescaler = guard_reg[POS_PRESCALER +: 8];
  wire final_flip = framing_reg[POS_FINAL_FLIP];
  wire par_type = framing_reg[POS_PAR_TYPE];
  wire par_en = framing_reg[POS_PAR_EN];
  wire data_en = framing_reg[POS_DATA_EN];
  wire [1:0] stop_sym = framing_reg[POS_STOP_SYM +: 2];
  wire [1:0] start_sym = framing_reg[POS_START_SYM +: 2];
  wire [2:0] last_bits = framing_reg[POS_LAST_BITS +: 3];
  wire [2:0] first_bits = framing_reg[POS_FIRST_BITS +: 3];

  wire start_cmd = reg_wr && (reg_addr == OFS_COMMAND) && reg_wdata[POS_CMD_START];
  wire idle = (state_reg == ST_IDLE);
  wire go = idle && start_cmd;
  wire no_data = data_en && (count_reg == 9'h000);
  wire slot_end = (slot_reg == 9'h000);
  wire last_byte = (bytes_reg == 9'h001);
  wire parity_bit = par_acc_reg ^ par_type ^ (final_flip && last_byte);

  // register file
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      os_reg <= RST_OVERSHOOT;
      pp_reg <= RST_PULSE_PHASE;
      framing_reg <= RST_FRAMING;
      count_reg <= RST_BYTE_COUNT;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_OVERSHOOT: os_reg <= {reg_wdata[31:16], 11'h000, reg_wdata[4:0]};
        OFS_PULSE_PHASE: pp_reg <= {16'h0000, reg_wdata[15:0]};
        OFS_FRAMING: framing_reg <= {18'h0_0000, reg_wdata[13:0]};
        OFS_BYTE_COUNT: count_reg <= reg_wdata[8:0];
        default: ;
      endcase
    end
  end

  // the mode detector takes precedence over a software write in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      guard_reg <= RST_GUARD;
    end else if (md_valid) begin
      guard_reg <= {4'h0, md_wait_value, md_prescaler};
    end else if (reg_wr && reg_addr == OFS_GUARD) begin
      guard_reg <= {4'h0, reg_wdata[27:0]};
    end
  end

  // sticky error: a new error wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      no_data_reg <= 1'b0;
    end else if (go && no_data) begin
      no_data_reg <= 1'b1;
    end else if (reg_wr && reg_addr == OFS_STATUS && reg_wdata[POS_ST_NO_DATA]) begin
      no_data_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_OVERSHOOT: reg_rdata <= os_reg;
        OFS_PULSE_PHASE: reg_rdata <= pp_reg;
        OFS_GUARD: reg_rdata <= guard_reg;
        OFS_FRAMING: reg_rdata <= framing_reg;
        OFS_BYTE_COUNT: reg_rdata <= {23'h00_0000, count_reg};
        OFS_STATUS: reg_rdata <= {30'h0000_0000, no_data_reg, !idle};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // where to go once the guard time is over, and once the data are over
  rfe_state_t after_guard, after_data;
  always_comb begin
    if (start_sym != 2'b00) begin
      after_guard = ST_START;
    end else if (data_en) begin
      after_guard = ST_LOAD;
    end else if (stop_sym != 2'b00) begin
      after_guard = ST_STOP;
    end else begin
      after_guard = ST_IDLE;
    end
    if (stop_sym != 2'b00) begin
      after_data = ST_STOP;
    end else begin
      after_data = ST_IDLE;
    end
  end

  // bit window of the byte being loaded
  logic [2:0] lo_idx;
  logic [3:0] hi_end, nbits;
  always_comb begin
    lo_idx = 3'd0;
    hi_end = 4'd8;
    if (bytes_reg == count_reg && first_bits != 3'd0) begin
      lo_idx = 3'(4'd8 - {1'b0, first_bits});
    end
    if (last_byte && last_bits != 3'd0) begin
      hi_end = {1'b0, last_bits};
    end
    nbits = (hi_end > {1'b0, lo_idx}) ? 4'(hi_end - {1'b0, lo_idx}) : 4'd1;
  end

  // frame sequencer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      slot_reg <= 9'h000;
      pre_reg <= 8'h00;
      wait_reg <= 20'h0_0000;
      byte_reg <= 8'h00;
      idx_reg <= 3'd0;
      left_reg <= 4'd0;
      bytes_reg <= 9'h000;
      par_acc_reg <= 1'b0;
      pulse_go_reg <= 1'b0;
      byte_ready <= 1'b0;
      sym_strobe <= 1'b0;
      sym_code <= 2'b00;
      frame_done <= 1'b0;
    end else begin
      pulse_go_reg <= 1'b0;
      byte_ready <= 1'b0;
      sym_strobe <= 1'b0;
      frame_done <= 1'b0;
      if (!idle && !slot_end) begin
        slot_reg <= slot_reg - 9'h001;
      end
      case (state_reg)
        ST_IDLE: begin
          if (start_cmd && !no_data) begin
            bytes_reg <= count_reg;
            slot_reg <= SLOT_LAST;
            pre_reg <= phase;
            wait_reg <= wait_value;
            if (wait_value == 20'h0_0000) begin
              state_reg <= after_guard;
              sym_strobe <= (after_guard == ST_START) || (after_guard == ST_STOP);
              sym_code <= (after_guard == ST_START) ? 2'(start_sym - 2'b01) : stop_sym;
              frame_done <= (after_guard == ST_IDLE);
            end else begin
              state_reg <= ST_GUARD;
            end
          end
        end
        ST_GUARD: begin
          slot_reg <= SLOT_LAST;
          pre_reg <= pre_reg - 8'h01;
          if (pre_reg == 8'h00) begin
            pre_reg <= prescaler;
            wait_reg <= wait_reg - 20'h0_0001;
            if (wait_reg == 20'h0_0001) begin
              state_reg <= after_guard;
              sym_strobe <= (after_guard == ST_START) || (after_guard == ST_STOP);
              sym_code <= (after_guard == ST_START) ? 2'(start_sym - 2'b01) : stop_sym;
              frame_done <= (after_guard == ST_IDLE);
            end
          end
        end
        ST_START: begin
          if (slot_end) begin
            slot_reg <= SLOT_LAST;
            state_reg <= data_en ? ST_LOAD : after_data;
            sym_strobe <= !data_en && (stop_sym != 2'b00);
            sym_code <= stop_sym;
            frame_done <= !data_en && (stop_sym == 2'b00);
          end
        end
        ST_LOAD: begin
          if (byte_valid) begin
            byte_reg <= byte_data;
            byte_ready <= 1'b1;
            idx_reg <= lo_idx;
            left_reg <= nbits;
            par_acc_reg <= byte_data[lo_idx];
            pulse_go_reg <= byte_data[lo_idx];
            slot_reg <= SLOT_LAST;
            state_reg <= ST_DBIT;
          end
        end
        ST_DBIT: begin
          if (slot_end) begin
            slot_reg <= SLOT_LAST;
            if (left_reg > 4'd1) begin
              idx_reg <= idx_reg + 3'd1;
              left_reg <= left_reg - 4'd1;
              par_acc_reg <= par_acc_reg ^ byte_reg[idx_reg + 3'd1];
              pulse_go_reg <= byte_reg[idx_reg + 3'd1];
            end else if (par_en) begin
              state_reg <= ST_PAR;
              pulse_go_reg <= parity_bit;
            end else begin
              bytes_reg <= bytes_reg - 9'h001;
              state_reg <= last_byte ? after_data : ST_LOAD;
              sym_strobe <= last_byte && (stop_sym != 2'b00);
              sym_code <= stop_sym;
              frame_done <= last_byte && (stop_sym == 2'b00);
            end
          end
        end
        ST_PAR: begin
          if (slot_end) begin
            slot_reg <= SLOT_LAST;
            bytes_reg <= bytes_reg - 9'h001;
            state_reg <= last_byte ? after_data : ST_LOAD;
            sym_strobe <= last_byte && (stop_sym != 2'b00);
            sym_code <= stop_sym;
            frame_done <= last_byte && (stop_sym == 2'b00);
          end
        end
        ST_STOP: begin
          if (slot_end) begin
            state_reg <= ST_IDLE;
            frame_done <= 1'b1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // miller pulse: high for width plus one cycles, rising one cycle after the slot start
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_mod <= 1'b0;
      pulse_cnt_reg <= 8'h00;
    end else if (pulse_go_reg) begin
      tx_mod <= 1'b1;
      pulse_cnt_reg <= pulse_width;
    end else if (pulse_cnt_reg != 8'h00) begin
      pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
    end else begin
      tx_mod <= 1'b0;
    end
  end

  // overshoot shaping lags the rising edge by one cycle
  wire mod_rise = tx_mod && !mod_d_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mod_d_reg <= 1'b0;
      os_active_reg <= 1'b0;
      os_idx_reg <= 4'd0;
      os_left_reg <= 4'd0;
      tx_shape <= 1'b0;
    end else begin
      mod_d_reg <= tx_mod;
      if (mod_rise && os_on) begin
        os_active_reg <= (os_len != 4'd0);
        os_idx_reg <= 4'd14;
        os_left_reg <= os_len;
        tx_shape <= os_pat[15];
      end else if (os_active_reg) begin
        tx_shape <= os_pat[os_idx_reg];
        os_idx_reg <= os_idx_reg - 4'd1;
        os_left_reg <= os_left_reg - 4'd1;
        os_active_reg <= (os_left_reg != 4'd1);
      end else begin
        tx_shape <= 1'b0;
      end
    end
  end

  // helper: length of the current modulation pulse
  logic [8:0] hi_cnt_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hi_cnt_reg <= 9'h000;
    end else if (tx_mod) begin
      hi_cnt_reg <= hi_cnt_reg + 9'h001;
    end else begin
      hi_cnt_reg <= 9'h000;
    end
  end

  chk_pulse_width: assert property (@(posedge ref_clk) disable iff (!rst_n)
    // the helper counter lags the pulse by one cycle, so it ends one short of width plus one
    $fell(tx_mod) |-> $past(hi_cnt_reg) == {1'b0, $past(pulse_width)})
    else $error("modulation pulse length differs from width plus one");
  chk_first_phase: assert property (@(posedge ref_clk) disable iff (!rst_n)
    go && !no_data && wait_value != 20'h0_0000 |=> state_reg == ST_GUARD && pre_reg == $past(phase))
    else $error("first prescaler load is not the bit-phase value");
  chk_prescaler_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg == ST_GUARD && pre_reg != 8'h00 |=> pre_reg == $past(pre_reg) - 8'h01)
    else $error("prescaler did not decrement");
  chk_wait_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg == ST_GUARD && pre_reg == 8'h00 && wait_reg > 20'h0_0001 && !md_valid
      |=> wait_reg == $past(wait_reg) - 20'h0_0001 && pre_reg == $past(prescaler) && state_reg == ST_GUARD)
    else $error("wrap did not step wait counter and reload prescaler");
  chk_guard_skip: assert property (@(posedge ref_clk) disable iff (!rst_n)
    go && !no_data && wait_value == 20'h0_0000 && start_sym == 2'b00 && data_en |=> state_reg == ST_LOAD)
    else $error("zero wait value did not skip the guard time");
  chk_no_data_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    go && no_data |=> no_data_reg && state_reg == ST_IDLE)
    else $error("empty data frame not flagged");
  chk_shape_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !os_active_reg && !(mod_rise && os_on) |=> !tx_shape)
    else $error("shaping output active without protection");
  chk_shape_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mod_rise && os_on && os_len == 4'd1 |=> tx_shape == $past(os_pat[15]) ##1 tx_shape == $past(os_pat[14], 2)
      ##1 !tx_shape)
    else $error("overshoot pattern not sent msb first for its length");
  chk_parity_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg == ST_DBIT && slot_end && left_reg == 4'd1 && par_en
      |=> state_reg == ST_PAR && pulse_go_reg == $past(parity_bit))
    else $error("parity slot missing or wrong value");
endmodule

//--- testbench/rfe_card_model.sv
`timescale 1ns/100ps
// passive far-side receiver: counts pulses, widths, shape samples and symbols
module rfe_card_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // modulation side
  input wire logic tx_mod,
  input wire logic tx_shape,
  input wire logic sym_strobe,
  input wire logic [1:0] sym_code
);
  int rises = 0;
  int width = 0;
  int run = 0;
  int sc = 0;
  int sym_n = 0;
  logic [1:0] sym_first = 2'h0;
  logic [1:0] sym_last = 2'h0;
  logic [15:0] shp = 16'h0000;
  logic mod_q = 1'b0;
  // only called while idle, so no edge update competes with it
  task clr();
    rises = 0;
    sym_n = 0;
  endtask
  always @(posedge ref_clk) begin
    mod_q <= rst_n & tx_mod;
    if (rst_n && tx_mod && !mod_q) begin
      rises <= rises + 1;
      sc <= 1;
      shp <= 16'h0000;
    end else if (sc != 0 && sc <= 16) begin
      shp <= {shp[14:0], tx_shape};
      sc <= sc + 1;
    end
    if (tx_mod) begin
      run <= run + 1;
    end else if (run != 0) begin
      width <= run;
      run <= 0;
    end
    if (sym_strobe) begin
      if (sym_n == 0) begin
        sym_first <= sym_code;
      end
      sym_last <= sym_code;
      sym_n <= sym_n + 1;
    end
  end
endmodule

//--- testbench/tb.sv
`timescale 1ns/100ps
module tb;
  import rfe_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic md_valid = 1'b0;
  logic [19:0] md_wait_value = 20'h0_0000;
  logic [7:0] md_prescaler = 8'h00;
  logic [7:0] byte_data = 8'h00;
  logic byte_valid = 1'b0;
  logic byte_ready;
  logic tx_mod;
  logic tx_shape;
  logic sym_strobe;
  logic [1:0] sym_code;
  logic frame_done;
  logic [7:0] bq [0:1];
  logic [7:0] ra [0:6] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h1D, 8'h1E, 8'h20};
  logic [31:0] rm [0:6] = '{32'hFFFF_001F, 32'h0000_FFFF, 32'h0FFF_FFFF, 32'h0000_3FFF, 32'h0000_01FF, 0, 0};
  int gp [0:4] = '{0, 5, 0, 255, 9};
  int gw [0:4] = '{0, 3, 2, 1, 0};
  int gs [0:4] = '{0, 2, 127, 0, 5};
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int lat0 = 0;
  int lat = 0;
  int n, f, l, wd, len, on, er;
  logic [15:0] pat;
  logic [15:0] msk;
  logic [31:0] rv;
  always #2 ref_clk = ~ref_clk;
  rfe_tx_encoder dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .md_valid(md_valid),
    .md_wait_value(md_wait_value), .md_prescaler(md_prescaler), .byte_data(byte_data),
    .byte_valid(byte_valid), .byte_ready(byte_ready), .tx_mod(tx_mod), .tx_shape(tx_shape),
    .sym_strobe(sym_strobe), .sym_code(sym_code), .frame_done(frame_done));
  rfe_card_model card (.ref_clk(ref_clk), .rst_n(rst_n), .tx_mod(tx_mod), .tx_shape(tx_shape),
    .sym_strobe(sym_strobe), .sym_code(sym_code));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask
  task automatic run_frame(output int lt);
    int k;
    k = 0;
    lt = -1;
    card.clr();
    // start strobe issued inline so the first symbol strobe is not missed
    reg_addr <= OFS_COMMAND;
    reg_wdata <= 32'h0000_0001;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    while (k < 20000 && frame_done !== 1'b1) begin
      @(posedge ref_clk);
      k++;
      if (sym_strobe === 1'b1 && lt < 0) lt = k;
    end
    chk("frame end", k < 20000, 1);
    repeat (2) @(posedge ref_clk);
  endtask
  // pulses expected on the field: one per sent '1' data bit plus each '1' parity bit
  function automatic int exp_rises(int nb, int fb, int lb, logic [2:0] pm);
    int tot, c, lo, hi;
    logic [7:0] b;
    tot = 0;
    for (int i = 0; i < nb; i++) begin
      b = bq[i];
      lo = (i == 0 && fb != 0) ? 8 - fb : 0;
      hi = (i == nb - 1 && lb != 0) ? lb - 1 : 7;
      c = 0;
      for (int j = lo; j <= hi; j++) c += b[j];
      tot += c;
      if (pm[0]) tot += (c % 2) ^ pm[1] ^ (pm[2] && i == nb - 1);
    end
    return tot;
  endfunction
  always @(posedge ref_clk) begin
    if (byte_ready === 1'b1) byte_data <= bq[1];
    cyc++;
    if (cyc == 95000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(32'hb26a));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    byte_valid <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], rv);
      chk("reset value", rv, 0);
      rv = $urandom();
      wr(ra[i], rv);
      rd(ra[i], reg_wdata);
      chk("readback", reg_wdata, rv & rm[i]);
    end
    md_valid <= 1'b1;
    md_wait_value <= 20'($urandom());
    md_prescaler <= 8'($urandom());
    @(posedge ref_clk);
    md_valid <= 1'b0;
    rd(OFS_GUARD, rv);
    chk("detector load", rv, {4'h0, md_wait_value, md_prescaler});
    wr(OFS_FRAMING, 32'h0000_0400);
    wr(OFS_BYTE_COUNT, 0);
    wr(OFS_COMMAND, 32'h0000_0001);
    @(posedge ref_clk);
    rd(OFS_STATUS, rv);
    chk("no data flag", rv, 32'h0000_0002);
    wr(OFS_STATUS, 32'h0000_0002);
    rd(OFS_STATUS, rv);
    chk("flag cleared", rv, 0);
    // guard length measured against the zero-guard frame; case 2 uses the 7F reload
    wr(OFS_FRAMING, 32'h0000_0040);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_PULSE_PHASE, gp[i]);
      wr(OFS_GUARD, (gw[i] << 8) | gs[i]);
      run_frame(lat);
      if (i == 0) lat0 = lat;
      er = gw[i] ? (gp[i] + 1) + (gw[i] - 1) * (gs[i] + 1) : 0;
      chk("guard length", lat - lat0, er);
    end
    for (int s = 0; s < 4; s++) begin
      for (int e = 0; e < 4; e++) begin
        wr(OFS_FRAMING, (e << 8) | (s << 6));
        run_frame(lat);
        chk("symbol count", card.sym_n, (s != 0) + (e != 0));
        chk("no data pulses", card.rises, 0);
        if (s != 0) chk("start symbol", card.sym_first, s - 1);
        if (e != 0) chk("stop symbol", card.sym_last, e);
      end
    end
    for (int k = 0; k < 8; k++) begin
      n = 1 + $urandom_range(1);
      bq[0] = 8'($urandom());
      bq[1] = 8'($urandom());
      f = $urandom_range(7);
      l = $urandom_range(7);
      if (n == 1 && f != 0 && l != 0 && 8 - f > l - 1) f = 0;
      if (k == 0) f = 0;
      if (k == 1) l = 1;
      wd = $urandom_range(255);
      pat = 16'($urandom());
      len = $urandom_range(15);
      on = $urandom_range(1);
      wr(OFS_OVERSHOOT, {pat, 11'h000, 4'(len), 1'(on)});
      wr(OFS_PULSE_PHASE, wd << 8);
      wr(OFS_BYTE_COUNT, n);
      wr(OFS_FRAMING, (k << 11) | 32'h0000_0400 | (l << 3) | f);
      byte_data <= bq[0];
      run_frame(lat);
      er = exp_rises(n, f, l, 3'(k));
      chk("pulse count", card.rises, er);
      if (er > 0) begin
        msk = ~(16'hFFFF >> (len + 1));
        chk("pulse width", card.width, wd + 1);
        chk("shape", on ? card.shp & msk : card.shp, on ? pat & msk : 0);
      end
    end
    give_verdict();
  end
endmodule
